/* File: include/srseq_defines.vh */
// Notes on behaviour
// R1 - Supply below threshold, including battery insertion or removal, forces power-on reset.
// R2 - On supply rise, hold power-on reset until internal voltages report settled.
// R3 - After power-on reset release, boot runs from the 3 MHz RC clock.
// R4 - Software request or watchdog expiry issues a system reset.
// R5 - Clock detector reporting invalid or missing clock issues a system reset.
// R6 - Low level on external reset pin resets the system; agent drives it low.
// R7 - All sources merge into one reset, released through a two-stage synchroniser.
`ifndef SRSEQ_DEFINES_VH
`define SRSEQ_DEFINES_VH
// RC boot clock rate and reference clock rate, in kHz
`define SRSEQ_RC_KHZ 3000
`define SRSEQ_REF_KHZ 40000
// Reference cycles per RC boot clock period, rounded down (13)
`define SRSEQ_RC_DIV (`SRSEQ_REF_KHZ / `SRSEQ_RC_KHZ)
// Divider counter width
`define SRSEQ_DIV_W 4
// Divider count that ends an RC period (13 - 1)
`define SRSEQ_DIV_LAST 4'hC
// Divider count at which the boot clock falls: high six cycles, low seven
`define SRSEQ_DIV_FALL 4'h5
// Cause word under srst: power-on only
`define SRSEQ_CAUSE_RST 5'h01
// Source cause bit positions
`define SRSEQ_CAUSE_POR 0
`define SRSEQ_CAUSE_SW 1
`define SRSEQ_CAUSE_WDT 2
`define SRSEQ_CAUSE_CLK 3
`define SRSEQ_CAUSE_PIN 4
`define SRSEQ_CAUSE_W 5
`endif

/* File: hw/srseq_sync2.v */
`timescale 1ns/10ps
`include "srseq_defines.vh"
// Two flip-flop synchroniser with a set value under reset
module srseq_sync2 #(
    parameter RST_VAL = 1'b0
)
(
    // Clock and reset
    input wire ref_clk,
    input wire srst,
    // Data
    input wire d,
    output wire q
);
    reg meta_r;
    reg sync_r;
    // First stage read only by second stage
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end
        else
        begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end
    assign q = sync_r;
endmodule

/* File: hw/srseq_top.v */
`timescale 1ns/10ps
`include "srseq_defines.vh"
// System reset sequencer: merges all reset sources into one system reset
module srseq_top
(
    // Clock and reset
    input wire ref_clk,
    input wire srst,
    // Supply monitor
    input wire supply_below_por,
    input wire supply_settled,
    // Other reset sources
    input wire sw_reset_req,
    input wire wdt_expired,
    input wire clk_invalid,
    input wire external_reset_pin_n,
    // Outputs
    output reg sys_reset_r,
    output reg por_active_r,
    output reg rc_boot_clock,
    output reg boot_start_r,
    output reg [`SRSEQ_CAUSE_W-1:0] reset_cause_r
);
    // Synchronised copies of the asynchronous sources
    wire below_s;
    wire settled_s;
    wire wdt_s;
    wire clk_bad_s;
    wire pin_n_s;
    // Boot clock divider state and next values
    reg [`SRSEQ_DIV_W-1:0] div_cnt_r;
    reg [`SRSEQ_DIV_W-1:0] div_cnt_nxt;
    reg rc_tick_r;
    reg rc_tick_nxt;
    reg rc_clk_nxt;
    // Release sequencer state and next values
    reg [1:0] rel_state_r;
    reg [1:0] rel_state_nxt;
    reg sys_reset_nxt;
    reg por_active_nxt;
    reg boot_start_nxt;
    reg [`SRSEQ_CAUSE_W-1:0] reset_cause_nxt;
    // Merged view of all sources
    wire por_hold;
    wire sys_src;
    wire [`SRSEQ_CAUSE_W-1:0] cause_now;

    // Release states; binary coded, code 3 unused and falls back to hold
    localparam [1:0] ST_HOLD = 2'h0;
    localparam [1:0] ST_SYNC = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;

    // Supply flags start pessimistic so nothing runs before the monitor speaks
    srseq_sync2 #(
        .RST_VAL(1'h1)
    )
    u_below
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .d(supply_below_por),
        .q(below_s)
    );
    srseq_sync2 #(
        .RST_VAL(1'h0)
    )
    u_settled
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .d(supply_settled),
        .q(settled_s)
    );
    // Watchdog and clock detector flags idle low
    srseq_sync2 #(
        .RST_VAL(1'h0)
    )
    u_wdt
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .d(wdt_expired),
        .q(wdt_s)
    );
    srseq_sync2 #(
        .RST_VAL(1'h0)
    )
    u_clk
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .d(clk_invalid),
        .q(clk_bad_s)
    );
    // Pin idles high; same reset value, so no false pin request after srst
    srseq_sync2 #(
        .RST_VAL(1'h1)
    )
    u_pin
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .d(external_reset_pin_n),
        .q(pin_n_s)
    );

    // Power-on reset while the supply is low or not yet settled
    assign por_hold = below_s | ~settled_s; // R1 R2
    // Software request is same-domain logic and needs no synchroniser
    assign cause_now[`SRSEQ_CAUSE_POR] = por_hold; // R1 R2
    assign cause_now[`SRSEQ_CAUSE_SW] = sw_reset_req; // R4
    assign cause_now[`SRSEQ_CAUSE_WDT] = wdt_s; // R4
    assign cause_now[`SRSEQ_CAUSE_CLK] = clk_bad_s; // R5
    assign cause_now[`SRSEQ_CAUSE_PIN] = ~pin_n_s; // R6
    // Any one source is enough to hold the system
    assign sys_src = |cause_now; // R7

    // Boot clock divider: 13 reference cycles per RC period, high six, low seven
    always @*
    begin
        div_cnt_nxt = div_cnt_r + 4'h1;
        rc_tick_nxt = 1'h0;
        rc_clk_nxt = rc_boot_clock;
        if (div_cnt_r == `SRSEQ_DIV_LAST)
        begin
            div_cnt_nxt = 4'h0;
            rc_tick_nxt = 1'h1;
            rc_clk_nxt = 1'h1; // R3
        end
        else if (div_cnt_r == `SRSEQ_DIV_FALL)
        begin
            rc_clk_nxt = 1'h0; // R3
        end
    end

    // Divider registers; the tick is a one-cycle enable, not a second clock
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            div_cnt_r <= 4'h0;
            rc_tick_r <= 1'h0;
            rc_boot_clock <= 1'h0;
        end
        else
        begin
            div_cnt_r <= div_cnt_nxt;
            rc_tick_r <= rc_tick_nxt;
            rc_boot_clock <= rc_clk_nxt;
        end
    end

    // Release sequencer: assertion at once, release after two quiet RC ticks
    always @*
    begin
        rel_state_nxt = rel_state_r;
        sys_reset_nxt = sys_reset_r;
        por_active_nxt = por_active_r;
        boot_start_nxt = 1'h0;
        reset_cause_nxt = reset_cause_r;
        if (sys_src)
        begin
            // A source returning mid-release restarts the count
            rel_state_nxt = ST_HOLD; // R7
            sys_reset_nxt = 1'h1; // R4 R5 R6
            if (por_hold)
            begin
                por_active_nxt = 1'h1; // R1 R2
            end
            // Fresh reset reloads the causes, an ongoing one gathers them
            if (rel_state_r == ST_RUN)
            begin
                reset_cause_nxt = cause_now;
            end
            else
            begin
                reset_cause_nxt = reset_cause_r | cause_now;
            end
        end
        else if (rc_tick_r)
        begin
            case (rel_state_r)
                ST_HOLD:
                begin
                    // First synchroniser stage
                    rel_state_nxt = ST_SYNC; // R7
                end
                ST_SYNC:
                begin
                    // Second stage: release and start boot on the RC clock
                    rel_state_nxt = ST_RUN; // R7
                    sys_reset_nxt = 1'h0;
                    por_active_nxt = 1'h0;
                    boot_start_nxt = 1'h1; // R3
                end
                ST_RUN:
                begin
                    rel_state_nxt = ST_RUN;
                end
                default:
                begin
                    rel_state_nxt = ST_HOLD;
                end
            endcase
        end
    end

    // Sequencer registers; srst loads the reset defaults, which a lone supply drop from run also reaches
    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            rel_state_r <= ST_HOLD;
            sys_reset_r <= 1'h1;
            por_active_r <= 1'h1;
            boot_start_r <= 1'h0;
            reset_cause_r <= `SRSEQ_CAUSE_RST; // R1
        end
        else
        begin
            rel_state_r <= rel_state_nxt;
            sys_reset_r <= sys_reset_nxt;
            por_active_r <= por_active_nxt;
            boot_start_r <= boot_start_nxt;
            reset_cause_r <= reset_cause_nxt;
        end
    end
endmodule

/* File: tb/srseq_checker.sv */
`timescale 1ns/10ps
// Source to reset timing and boot clock shape
module srseq_checker (
    // Inputs of the sequencer
    input wire ref_clk, srst, supply_below_por, supply_settled, sw_reset_req,
    input wire wdt_expired, clk_invalid, external_reset_pin_n,
    // Outputs of the sequencer
    input wire sys_reset_r, por_active_r, rc_boot_clock, boot_start_r,
    input wire [4:0] reset_cause_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // High six cycles then low seven, since 13 does not split evenly
    sequence rc_period; rc_boot_clock[*6] ##1 !rc_boot_clock[*7]; endsequence
    por_hold_a: assert property (supply_below_por |-> ##3 sys_reset_r)
        else $error("no reset after supply drop");
    settle_wait_a: assert property (!supply_settled |-> ##3 sys_reset_r)
        else $error("released before supply settled");
    sw_req_a: assert property (sw_reset_req |=> sys_reset_r)
        else $error("no reset after software request");
    wdt_exp_a: assert property (wdt_expired |-> ##3 sys_reset_r)
        else $error("no reset after watchdog expiry");
    clk_bad_a: assert property (clk_invalid |-> ##3 sys_reset_r)
        else $error("no reset after clock failure");
    pin_low_a: assert property (!external_reset_pin_n |-> ##3 sys_reset_r)
        else $error("no reset while pin low");
    rc_shape_a: assert property ($rose(rc_boot_clock) |-> rc_period)
        else $error("boot clock period wrong");
    boot_pulse_a: assert property (boot_start_r == $fell(sys_reset_r))
        else $error("boot start not at release");
    por_flag_a: assert property (supply_below_por |-> ##3 por_active_r)
        else $error("power-on flag not raised");
    boot_run_a: assert property (boot_start_r |-> !sys_reset_r && !por_active_r)
        else $error("boot started while held");
endmodule
bind srseq_top srseq_checker chk (.*);

/* File: tb/srseq_supply_model.sv */
`timescale 1ns/10ps
// Battery monitor and reset pin driver on the far side
module srseq_supply_model #(parameter SETTLE = 30) (
    input wire ref_clk, batt_on, pin_press,
    output logic supply_below_por = 1'b1, supply_settled = 1'b0,
    output logic external_reset_pin_n = 1'b1
);
    int cnt = 0;
    // Voltages settle only a while after the battery returns
    always @(posedge ref_clk)
    begin
        cnt <= batt_on ? cnt + 1 : 0;
        supply_below_por <= #1 !batt_on;
        supply_settled <= #1 batt_on && cnt >= SETTLE;
        external_reset_pin_n <= #1 !pin_press;
    end
endmodule

/* File: tb/system_reset_sequencer_test.sv */
`timescale 1ns/10ps
module system_reset_sequencer_test;
    logic ref_clk = 0, srst = 1, batt_on = 1, pin_press = 0;
    logic sw_reset_req = 0, wdt_expired = 0, clk_invalid = 0;
    wire supply_below_por, supply_settled, external_reset_pin_n;
    wire sys_reset_r, por_active_r, rc_boot_clock, boot_start_r;
    wire [4:0] reset_cause_r;
    int fails = 0, check_count = 0, cyc = 0, src, n;
    srseq_top dut (.*);
    srseq_supply_model model (.*);
    // Clock and hang guard
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            end_of_test();
        end
    end
    task automatic check(string what, logic [4:0] seen, logic [4:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Cause bits follow source order
    function automatic logic [4:0] exp_cause(int s);
        return 5'h01 << s;
    endfunction
    task set_src(int s, logic v);
        case (s)
            0: batt_on = !v;
            1: sw_reset_req = v;
            2: wdt_expired = v;
            3: clk_invalid = v;
            default: pin_press = v;
        endcase
    endtask
    // Latest release: sync plus two RC ticks; supply adds the model's settle time
    function automatic int rel_max(int s);
        return (s == 0) ? 70 : 40;
    endfunction
    // Bounded wait for the release pulse, then its timing
    task wait_boot(int hi);
        n = 0;
        while (boot_start_r !== 1'b1 && n < 400)
        begin
            @(posedge ref_clk) #1 n++;
        end
        check("boot", {4'h0, boot_start_r}, 5'h01);
        check("por", {4'h0, por_active_r}, 5'h00);
        check("release", {4'h0, n >= 14 && n <= hi}, 5'h01);
    endtask
    // Random sources, each held a random span, then released
    initial
    begin
        void'($urandom(80));
        repeat (3) @(posedge ref_clk);
        #1 srst = 0;
        check("cause", reset_cause_r, 5'h01);
        wait_boot(70);
        check("cause", reset_cause_r, 5'h01);
        repeat (40)
        begin
            src = $urandom_range(4);
            @(posedge ref_clk) #1 set_src(src, 1);
            repeat (4 + $urandom_range(10)) @(posedge ref_clk);
            #1 check("held", {4'h0, sys_reset_r}, 5'h01);
            check("cause", reset_cause_r, exp_cause(src));
            check("por", {4'h0, por_active_r}, {4'h0, src == 0});
            set_src(src, 0);
            wait_boot(rel_max(src));
        end
        // Corner: two sources overlap and their causes merge
        @(posedge ref_clk) #1 set_src(2, 1);
        set_src(4, 1);
        repeat (6) @(posedge ref_clk);
        #1 check("merge", reset_cause_r, exp_cause(2) | exp_cause(4));
        set_src(2, 0);
        set_src(4, 0);
        wait_boot(40);
        // Corner: a request inside the release count restarts it
        @(posedge ref_clk) #1 set_src(1, 1);
        @(posedge ref_clk) #1 set_src(1, 0);
        repeat (10) @(posedge ref_clk);
        #1 set_src(1, 1);
        @(posedge ref_clk) #1 set_src(1, 0);
        check("restart", {4'h0, sys_reset_r}, 5'h01);
        wait_boot(40);
        // Corner: second srst in mid-run brings back the power-on state
        @(posedge ref_clk) #1 srst = 1;
        repeat (3) @(posedge ref_clk);
        #1 srst = 0;
        check("cause", reset_cause_r, 5'h01);
        check("por", {4'h0, por_active_r}, 5'h01);
        wait_boot(40);
        end_of_test();
    end
endmodule
